// File: dv/flg_fw_model.sv
`timescale 1ns/10ps
`default_nettype none
module flg_fw_model
(
  // Clock and reset
  input wire logic                     clock,
  input wire logic                     rst,
  // Command from the bench
  input wire logic                     cmdValid,
  input wire flg_guard_pkg::flg_req_t  cmd,
  // Request toward the guard
  input wire logic                     ready,
  output flg_guard_pkg::flg_req_t      req
);
  import flg_guard_pkg::*;
  flg_req_t next_req;
  // Hold a request until taken; idle address toggles so stale values never look valid
  always_comb
  begin
    next_req = req;
    if (req.valid)
      next_req.valid = !ready;
    else if (cmdValid)
      next_req = cmd;
    else
      next_req.addr = ~req.addr;
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      req <= '0;
    else
      req <= next_req;
  end
endmodule
`default_nettype wire

// File: dv/flg_guard_sva.sv
`timescale 1ns/10ps
`default_nettype none
module flg_guard_sva
(
  // Clock and resets
  input wire logic                     clock,
  input wire logic                     rst,
  input wire logic                     devReset,
  // Request, verdict and status
  input wire flg_guard_pkg::flg_req_t  req,
  input wire flg_guard_pkg::flg_rsp_t  rsp,
  input wire logic                     ready,
  input wire logic                     flashErrorReset,
  input wire logic                     flashErrorFlag,
  input wire flg_guard_pkg::flg_ctrl_t ctrlOut,
  input wire flg_guard_pkg::flg_mon_t  monOut,
  input wire logic [7:0]               lockActive
);
  import flg_guard_pkg::*;
  // ----------------
  // Sequences
  // ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Both monitor enables must be on
  logic monOk;
  assign monOk = monOut.monEnable && monOut.monResetEnable;
  sequence take;
    req.valid && ready;
  endsequence
  sequence fwWrite;
    take ##0 (!req.debug && req.op == OP_WRITE);
  endsequence
  sequence dbgTake;
    take ##0 (req.debug && req.op != OP_DEV_ERASE);
  endsequence
  // ----------------
  // Assertions
  // ----------------
  a_answer_has_take: assert property (
    (rsp.grant || rsp.deny || flashErrorReset) |-> $past(req.valid && ready))
    else $error("verdict without a request");
  a_one_verdict: assert property (
    $onehot0({rsp.grant, rsp.deny, flashErrorReset}))
    else $error("more than one verdict");
  a_write_needs_enable: assert property (
    fwWrite ##0 !ctrlOut.storeWriteEnable |=> !rsp.grant)
    else $error("write granted without write enable");
  a_erase_needs_both: assert property (
    (rsp.grant && rsp.erase && !$past(req.debug))
      |-> $past(ctrlOut.storeWriteEnable && ctrlOut.storeEraseEnable))
    else $error("erase without both enables");
  a_erase_when_both: assert property (
    fwWrite ##0 (ctrlOut.storeWriteEnable && ctrlOut.storeEraseEnable)
      |=> !rsp.grant || rsp.erase)
    else $error("write with both enables not an erase");
  a_debug_no_reset: assert property (
    take ##0 req.debug |=> !flashErrorReset)
    else $error("debug access caused a reset");
  a_error_sets_flag: assert property (
    flashErrorReset |-> flashErrorFlag ##1 flashErrorFlag)
    else $error("error flag not set");
  a_monitor_gate: assert property (
    fwWrite ##0 (ctrlOut.storeWriteEnable && !monOk) |=> flashErrorReset)
    else $error("write with monitor off not reset");
  a_reserved_debug: assert property (
    dbgTake ##0 (req.addr[15:10] == 6'h3F) |=> rsp.deny)
    else $error("debug reserved access not denied");
  a_locked_debug: assert property (
    dbgTake ##0 ({2'b00, req.addr[15:10]} < ~lockActive && req.addr[15:10] != 6'h3E)
      |=> rsp.deny)
    else $error("debug locked access not denied");
  a_lock_page_erase: assert property (
    fwWrite ##0 (ctrlOut.storeWriteEnable && ctrlOut.storeEraseEnable && monOk
      && req.addr[15:10] == 6'h3E) |=> flashErrorReset)
    else $error("lock page erase not reset");
  a_busy_span: assert property (
    @(posedge clock) disable iff (rst || devReset)
    (rsp.grant && $past(req.op) != OP_READ) |-> !ready [*5] ##1 ready)
    else $error("busy span wrong");
  a_power_on_mon: assert property (
    $past(rst) |-> monOut == 2'b11)
    else $error("monitor not on after power-on");
endmodule

bind flg_guard flg_guard_sva chk_u
(
  .clock(clock),
  .rst(rst),
  .devReset(devReset),
  .req(req),
  .rsp(rsp),
  .ready(ready),
  .flashErrorReset(flashErrorReset),
  .flashErrorFlag(flashErrorFlag),
  .ctrlOut(ctrlOut),
  .monOut(monOut),
  .lockActive(lockActive)
);
`default_nettype wire

// File: dv/flg_guard_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin nMismatch++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module flg_guard_tb;
  import flg_guard_pkg::*;
  localparam logic [7:0] VARIANT = 8'h5A; // Arbitrary value
  logic       clock = 1'b0, rst = 1'b1, devReset = 1'b0, ctrlWrite = 1'b0, monWrite = 1'b0;
  logic       cmdValid = 1'b0, irqEnable = 1'b0, ready, errRst, errFlag;
  logic [7:0] lockStored = 8'hFD, lockActive, irqIn = 8'h00, irqOut, lockCur;
  flg_ctrl_t  ctrlIn = '0, ctrlOut, ctrlCur;
  flg_mon_t   monIn = '0, monOut, monCur;
  flg_req_t   cmd = '0, req;
  flg_rsp_t   rsp;
  int         nMismatch = 0, nTests = 0, cyc = 0;
  always #4 clock = ~clock;
  flg_guard #(.VARIANT_ID(VARIANT)) dut_u (.clock(clock), .rst(rst), .devReset(devReset),
    .ctrlWrite(ctrlWrite), .ctrlIn(ctrlIn), .monWrite(monWrite), .monIn(monIn),
    .lockByteStored(lockStored), .req(req), .rsp(rsp), .ready(ready),
    .flashErrorReset(errRst), .flashErrorFlag(errFlag), .ctrlOut(ctrlOut),
    .monOut(monOut), .lockActive(lockActive), .irqIn(irqIn), .irqEnable(irqEnable),
    .irqOut(irqOut));
  flg_fw_model host_u (.clock(clock), .rst(rst), .cmdValid(cmdValid), .cmd(cmd),
    .ready(ready), .req(req));
  // ----------------
  // Helpers
  // ----------------
  task automatic finishTest;
    $display("mismatches %0d tests %0d", nMismatch, nTests);
    if (nMismatch == 0 && nTests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard, well above the several hundred cycles needed
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      nMismatch++;
      finishTest();
    end
  end
  // Expected verdict: 0 grant, 1 deny, 2 error reset
  function automatic logic [1:0] expKind(logic dbg, flg_op_e_t op, logic [15:0] a, f);
    logic any, lk, flk, rsv;
    any = lockCur != 8'hFF;
    rsv = a[15:10] == 6'h3F;
    lk = (a[15:10] == 6'h3E) ? any : ({2'b00, a[15:10]} < ~lockCur);
    flk = (f[15:10] == 6'h3E) ? any : ({2'b00, f[15:10]} < ~lockCur);
    // Scratchpad hides lock and reserved pages from firmware
    if (!dbg && ctrlCur.scratchpadSelect)
    begin
      rsv = 1'b0;
      lk = ~lockCur >= 8'd62;
    end
    if (dbg)
      return (op != OP_DEV_ERASE && (rsv || lk)) ? 2'd1 : 2'd0;
    if (op == OP_DEV_ERASE)
      return 2'd1;
    if (op == OP_READ)
      return (a != 16'hFFFE && (rsv || (lk && !flk))) ? 2'd2 : 2'd0;
    if (!ctrlCur.storeWriteEnable)
      return 2'd1;
    if (monCur != 2'b11 || rsv || (ctrlCur.storeEraseEnable && a[15:10] == 6'h3E))
      return 2'd2;
    return (lk && !flk) ? 2'd2 : 2'd0;
  endfunction
  task automatic waitReady;
    @(negedge clock);
    for (int i = 0; i < 50 && ready !== 1'b1; i++)
      @(negedge clock);
  endtask
  task automatic setCfg(flg_ctrl_t c, flg_mon_t m);
    @(posedge clock);
    ctrlWrite <= 1'b1;
    ctrlIn <= c;
    monWrite <= 1'b1;
    monIn <= m;
    @(posedge clock);
    ctrlWrite <= 1'b0;
    monWrite <= 1'b0;
    ctrlCur = c;
    monCur = m;
  endtask
  task automatic pulseReset;
    @(posedge clock);
    devReset <= 1'b1;
    @(posedge clock);
    devReset <= 1'b0;
    waitReady();
    lockCur = lockStored;
    ctrlCur = '0;
  endtask
  // One request through the partner, verdict checked in the answer cycle
  task automatic doReq(logic dbg, flg_op_e_t op, logic [15:0] a, f);
    logic [1:0] k, got;
    k = expKind(dbg, op, a, f);
    @(posedge clock);
    cmdValid <= 1'b1;
    cmd <= '{1'b1, dbg, op, a, f};
    @(posedge clock);
    cmdValid <= 1'b0;
    @(negedge clock);
    for (int i = 0; i < 50 && !(req.valid && ready); i++)
      @(negedge clock);
    @(negedge clock);
    got = errRst ? 2'd2 : rsp.deny ? 2'd1 : rsp.grant ? 2'd0 : 2'd3;
    `CHK("verdict", k, got)
    if (k == 2'd0 && !dbg && op == OP_WRITE)
      `CHK("erase", ctrlCur.storeEraseEnable, rsp.erase)
    if (k == 2'd0 && !dbg && op == OP_READ && a == 16'hFFFE)
    begin
      `CHK("variant", VARIANT, rsp.data)
      `CHK("idHit", 1'b1, rsp.idHit)
    end
    if (k == 2'd2)
    begin
      `CHK("errFlag", 1'b1, errFlag)
      `CHK("ctrlClr", 3'b000, ctrlOut)
      waitReady();
      lockCur = lockStored;
      ctrlCur = '0;
    end
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial
  begin
    logic [15:0] a;
    logic [7:0] q[$];
    void'($urandom(41));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    lockCur = 8'hFD;
    monCur = 2'b11;
    ctrlCur = '0;
    waitReady();
    `CHK("mon", 2'b11, monOut)
    `CHK("lock", 8'hFD, lockActive)
    doReq(1, OP_READ, 16'h07FF, 0);
    doReq(1, OP_READ, 16'h0800, 0);
    doReq(1, OP_READ, 16'hFBFF, 0);
    doReq(1, OP_READ, 16'hFC10, 0);
    doReq(0, OP_READ, 16'hFFFE, 16'h1400);
    doReq(0, OP_READ, 16'h0010, 16'h0400);
    doReq(0, OP_READ, 16'hFBFF, 16'h1400);
    doReq(0, OP_WRITE, 16'h1000, 16'h1400);
    setCfg(3'b001, 2'b01);
    doReq(0, OP_WRITE, 16'h1000, 16'h1400);
    setCfg(3'b011, 2'b11);
    doReq(0, OP_WRITE, 16'h0C00, 16'h1400);
    doReq(0, OP_WRITE, 16'hF800, 16'h0000);
    setCfg(3'b001, 2'b11);
    doReq(0, OP_WRITE, 16'h0400, 16'h0000);
    doReq(0, OP_WRITE, 16'h0400, 16'h2000);
    setCfg(3'b011, 2'b11);
    doReq(0, OP_WRITE, 16'hFC00, 16'h2000);
    setCfg(3'b111, 2'b11);
    doReq(0, OP_WRITE, 16'h0010, 16'h2000);
    doReq(0, OP_DEV_ERASE, 0, 0);
    // New lock byte must wait for a reset
    lockStored <= 8'hC1;
    repeat (4) @(negedge clock);
    `CHK("lockHeld", 8'hFD, lockActive)
    pulseReset();
    `CHK("lockNew", 8'hC1, lockActive)
    doReq(1, OP_READ, 16'hF400, 0);
    doReq(1, OP_WRITE, 16'hFBFF, 0);
    doReq(1, OP_DEV_ERASE, 0, 0);
    lockStored <= 8'hFF;
    lockCur = 8'hFF;
    `CHK("lockErased", 8'hFF, lockActive)
    doReq(1, OP_READ, 16'h0000, 0);
    doReq(1, OP_WRITE, 16'hF800, 0);
    setCfg(3'b011, 2'b11);
    doReq(0, OP_WRITE, 16'hF800, 16'h0000);
    // Interrupts arriving while the store is busy
    setCfg(3'b001, 2'b11);
    doReq(0, OP_WRITE, 16'h2000, 16'h0000);
    @(posedge clock);
    // Enabled early, so only the busy store can hold them
    irqIn <= 8'h0A;
    irqEnable <= 1'b1;
    @(posedge clock);
    irqIn <= 8'h00;
    for (int i = 0; i < 8 && ready !== 1'b1; i++)
    begin
      @(negedge clock);
      `CHK("irqHeld", 8'h00, irqOut)
    end
    @(posedge clock);
    irqEnable <= 1'b1;
    repeat (6)
    begin
      @(negedge clock);
      if (irqOut != 8'h00)
        q.push_back(irqOut);
    end
    `CHK("irqFirst", 8'h02, q[0])
    `CHK("irqSecond", 8'h08, q[1])
    // Random traffic over random lock settings
    for (int i = 0; i < 80; i++)
    begin
      if (i % 20 == 0)
      begin
        @(posedge clock);
        lockStored <= {2'b11, 6'($urandom)};
        pulseReset();
      end
      setCfg({1'b0, 1'($urandom), 1'b1}, 2'b11);
      a = 16'($urandom);
      if (a == 16'hFBFF)
        a = 16'hFBFE;
      doReq(1'($urandom), flg_op_e_t'($urandom % 2), a, 16'($urandom % 16'hFC00));
    end
    finishTest();
  end
endmodule
`default_nettype wire

// File: verilog/flg_guard.sv
`timescale 1ns/10ps
`default_nettype none
`include "flg_guard_regs.svh"
module flg_guard
#(
  parameter logic [7:0] VARIANT_ID = 8'h5A,   // Arbitrary value
  parameter int         IRQ_N      = 8
)
(
  // Clock and power-on reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // Device reset from other sources
  input  wire logic                     devReset,
  // Program store control and monitor writes
  input  wire logic                     ctrlWrite,
  input  wire flg_guard_pkg::flg_ctrl_t ctrlIn,
  input  wire logic                     monWrite,
  input  wire flg_guard_pkg::flg_mon_t  monIn,
  // Lock byte as held in the array
  input  wire logic [7:0]               lockByteStored,
  // Access request and verdict
  input  wire flg_guard_pkg::flg_req_t  req,
  output flg_guard_pkg::flg_rsp_t       rsp,
  output logic                          ready,
  // Error reset and status
  output logic                          flashErrorReset,
  output logic                          flashErrorFlag,
  output flg_guard_pkg::flg_ctrl_t      ctrlOut,
  output flg_guard_pkg::flg_mon_t       monOut,
  output logic [7:0]                    lockActive,
  // Interrupts
  input  wire logic [IRQ_N-1:0]         irqIn,
  input  wire logic                     irqEnable,
  output logic [IRQ_N-1:0]              irqOut
);
  import flg_guard_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    flg_phase_t              phase;
    logic [7:0]              lockCopy;
    flg_ctrl_t               ctrl;
    flg_mon_t                mon;
    logic                    errFlag;
    logic                    errReset;
    logic                    ready;
    flg_rsp_t                rsp;
    logic [`FLG_BUSY_W-1:0]  busyCnt;
  } flg_state_t;

  localparam logic [`FLG_BUSY_W-1:0] OP_CYCLES = `FLG_BUSY_W'(`FLG_OP_CYCLES);

  flg_state_t st;
  flg_state_t next_st;

  // ---------------------------------------------------------------
  // Page decode of target and of fetching code
  // ---------------------------------------------------------------
  logic anyLocked;
  logic tgtLocked;
  logic tgtLockPage;
  logic tgtReserved;
  logic codeLocked;
  logic scratchTarget;

  // Debug port never sees the scratchpad select
  assign scratchTarget = st.ctrl.scratchpadSelect && !req.debug;

  flg_page_decode u_target
  (
    .addr       (req.addr),
    .scratch    (scratchTarget),
    .lockByte   (st.lockCopy),
    .anyLocked  (anyLocked),
    .pageLocked (tgtLocked),
    .isLockPage (tgtLockPage),
    .isReserved (tgtReserved)
  );

  // Code page judged from the fetch address of the issuing instruction
  flg_page_decode u_code
  (
    .addr       (req.fetchAddr),
    .scratch    (1'b0),
    .lockByte   (st.lockCopy),
    .anyLocked  (),
    .pageLocked (codeLocked),
    .isLockPage (),
    .isReserved ()
  );

  // ---------------------------------------------------------------
  // Verdict helpers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {V_GRANT, V_DENY, V_RESET, V_IGNORE} flg_verdict_t;

  // Debug port verdict; violations only refuse, never reset
  function automatic flg_verdict_t debugVerdict(
    input flg_op_e_t op,
    input logic      eraseReq,
    input logic      locked,
    input logic      lockPage,
    input logic      reserved,
    input logic      anyLk
  );
    flg_verdict_t v;
    v = V_GRANT;
    if (op == OP_DEV_ERASE)
      v = V_GRANT;
    else if (reserved)
      v = V_DENY;
    else if (lockPage && eraseReq)
      v = anyLk ? V_DENY : V_GRANT;
    else if (lockPage)
      v = anyLk ? V_DENY : V_GRANT;
    else if (locked)
      v = V_DENY;
    return v;
  endfunction

  // Firmware verdict; violations force an error reset
  function automatic flg_verdict_t fwVerdict(
    input logic modify,
    input logic eraseReq,
    input logic monOk,
    input logic isId,
    input logic isLockByte,
    input logic locked,
    input logic lockPage,
    input logic reserved,
    input logic anyLk,
    input logic fromLocked
  );
    flg_verdict_t v;
    v = V_GRANT;
    if (modify && !monOk)
      v = V_RESET;
    else if (reserved)
      v = (isId && !modify) ? V_GRANT : V_RESET;
    else if (lockPage && eraseReq)
      v = V_RESET;
    else if (isLockByte && modify && anyLk)
      v = V_RESET;
    else if (lockPage && anyLk)
      v = fromLocked ? V_GRANT : V_RESET;
    else if (locked)
      v = fromLocked ? V_GRANT : V_RESET;
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Request classification
  // ---------------------------------------------------------------
  flg_verdict_t verdict;
  logic         fwModify;
  logic         fwErase;
  logic         dbgErase;
  logic         isIdAddr;
  logic         isLockByte;
  logic         monOk;

  always_comb
  begin
    // A firmware write only reaches flash with write enable set
    fwModify   = (req.op == OP_WRITE) && st.ctrl.storeWriteEnable;
    // Write plus both enables becomes a page erase
    fwErase    = fwModify && st.ctrl.storeEraseEnable;
    dbgErase   = (req.op == OP_DEV_ERASE);
    isIdAddr   = (req.addr == `FLG_ID_ADDR);
    isLockByte = (req.addr == `FLG_LOCK_ADDR) && !scratchTarget;
    monOk      = st.mon.monEnable && st.mon.monResetEnable;
    verdict    = V_IGNORE;
    if (req.valid && st.ready)
    begin
      if (req.debug)
        verdict = debugVerdict(req.op, dbgErase, tgtLocked, tgtLockPage,
                               tgtReserved, anyLocked);
      else if (req.op == OP_WRITE && !st.ctrl.storeWriteEnable)
        verdict = V_DENY;
      else if (req.op == OP_DEV_ERASE)
        verdict = V_DENY;
      else
        verdict = fwVerdict(fwModify, fwErase, monOk, isIdAddr, isLockByte,
                            tgtLocked, tgtLockPage, tgtReserved, anyLocked,
                            codeLocked);
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st          = st;
    next_st.errReset = 1'b0;
    next_st.rsp      = '0;
    next_st.ready    = 1'b0;
    case (st.phase)
      // Lock copy refreshed here and by a granted debug device erase, so a firmware write waits for reset
      PH_CAPTURE:
      begin
        next_st.lockCopy = lockByteStored;
        next_st.phase    = PH_RUN;
        next_st.ready    = 1'b1;
      end
      PH_RUN:
      begin
        next_st.ready = 1'b1;
        case (verdict)
          V_GRANT:
          begin
            next_st.rsp.grant = 1'b1;
            next_st.rsp.erase = req.debug ? (req.op == OP_DEV_ERASE) : fwErase;
            if (!req.debug && isIdAddr && req.op == OP_READ)
            begin
              next_st.rsp.idHit = 1'b1;
              next_st.rsp.data  = VARIANT_ID;
            end
            if (req.debug && req.op == OP_DEV_ERASE)
              next_st.lockCopy = `FLG_LOCK_ERASED;
            // Modifications stall further requests while the array works
            if (req.op != OP_READ)
            begin
              next_st.phase   = PH_BUSY;
              next_st.busyCnt = OP_CYCLES;
              next_st.ready   = 1'b0;
            end
          end
          V_DENY:
            next_st.rsp.deny = 1'b1;
          V_RESET:
          begin
            // Error reset acts like a device reset: controls cleared,
            // lock byte recaptured, flag left set for software
            next_st.errReset = 1'b1;
            next_st.errFlag  = 1'b1;
            next_st.ctrl     = `FLG_CTRL_RESET;
            next_st.phase    = PH_CAPTURE;
            next_st.ready    = 1'b0;
          end
          default:
            next_st.rsp = '0;
        endcase
      end
      PH_BUSY:
      begin
        if (st.busyCnt <= `FLG_BUSY_W'(1))
        begin
          next_st.busyCnt = '0;
          next_st.phase   = PH_RUN;
          next_st.ready   = 1'b1;
        end
        else
          next_st.busyCnt = st.busyCnt - `FLG_BUSY_W'(1);
      end
      default:
        next_st.phase = PH_CAPTURE;
    endcase

    // Software control writes; ignored in the cycle that raises an error reset
    if (ctrlWrite && !next_st.errReset)
      next_st.ctrl = ctrlIn;
    if (monWrite)
      next_st.mon = monIn;

    // Reset from another source recaptures the lock and clears the flag
    if (devReset)
    begin
      next_st.phase    = PH_CAPTURE;
      next_st.ctrl     = `FLG_CTRL_RESET;
      next_st.errFlag  = next_st.errReset;                     // Set wins
      next_st.errReset = 1'b0;
      next_st.ready    = 1'b0;
      next_st.rsp      = '0;
      next_st.busyCnt  = '0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Power-on reset: monitor and its reset enable come up on
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st          <= '0;
      st.phase    <= PH_CAPTURE;
      st.lockCopy <= `FLG_LOCK_ERASED;
      st.ctrl     <= `FLG_CTRL_RESET;
      st.mon      <= `FLG_MON_RESET;
    end
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // Interrupt hold during flash operations
  // ---------------------------------------------------------------
  flg_irq_hold #(.N(IRQ_N)) u_irq
  (
    .clock     (clock),
    .rst       (rst),
    .irqIn     (irqIn),
    .irqEnable (irqEnable),
    .busy      (st.phase == PH_BUSY),
    .irqOut    (irqOut)
  );

  // ---------------------------------------------------------------
  // Outputs, all from the state register
  // ---------------------------------------------------------------
  assign rsp             = st.rsp;
  assign ready           = st.ready;
  assign flashErrorReset = st.errReset;
  assign flashErrorFlag  = st.errFlag;
  assign ctrlOut         = st.ctrl;
  assign monOut          = st.mon;
  assign lockActive      = st.lockCopy;
endmodule
`default_nettype wire

// File: verilog/flg_guard_pkg.sv
`default_nettype none
package flg_guard_pkg;

  // Kind of flash access
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_DEV_ERASE} flg_op_e_t;

  // Access request from firmware or the debug port
  typedef struct packed {
    logic        valid;
    logic        debug;
    flg_op_e_t   op;
    logic [15:0] addr;
    logic [15:0] fetchAddr;
  } flg_req_t;

  // Verdict on one request
  typedef struct packed {
    logic       grant;
    logic       deny;
    logic       erase;
    logic       idHit;
    logic [7:0] data;
  } flg_rsp_t;

  // Program store control bits
  typedef struct packed {
    logic scratchpadSelect;
    logic storeEraseEnable;
    logic storeWriteEnable;
  } flg_ctrl_t;

  // Supply monitor enables
  typedef struct packed {
    logic monResetEnable;
    logic monEnable;
  } flg_mon_t;

  typedef enum logic [1:0] {PH_CAPTURE, PH_RUN, PH_BUSY} flg_phase_t;

endpackage
`default_nettype wire

// File: verilog/flg_guard_regs.svh
`ifndef FLG_GUARD_REGS_SVH
`define FLG_GUARD_REGS_SVH

// ---------------------------------------------------------------
// Flash map
// ---------------------------------------------------------------
`define FLG_ADDR_W        16
`define FLG_PAGE_LSB      10
`define FLG_PAGE_W        6
`define FLG_LOCK_PAGE     6'h3E
`define FLG_LOCK_ADDR     16'hFBFF
`define FLG_ID_ADDR       16'hFFFE

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define FLG_LOCK_ERASED   8'hFF
`define FLG_CTRL_RESET    3'h0
`define FLG_MON_RESET     2'h3

// ---------------------------------------------------------------
// Field positions of the control and monitor words
// ---------------------------------------------------------------
`define FLG_CTRL_WR_BIT   0
`define FLG_CTRL_ER_BIT   1
`define FLG_CTRL_SCR_BIT  2
`define FLG_MON_EN_BIT    0
`define FLG_MON_RST_BIT   1

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define FLG_CLK_NS        8
`define FLG_OP_TIME_NS    40
`define FLG_OP_CYCLES     ((`FLG_OP_TIME_NS + `FLG_CLK_NS - 1) / `FLG_CLK_NS)
`define FLG_BUSY_W        4

`endif

// File: verilog/flg_irq_hold.sv
`timescale 1ns/10ps
`default_nettype none
module flg_irq_hold
#(
  parameter int N = 8
)
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Interrupt sources and gating
  input  wire logic [N-1:0] irqIn,
  input  wire logic         irqEnable,
  input  wire logic         busy,
  // Serviced interrupt, one-hot
  output logic [N-1:0]      irqOut
);
  typedef struct packed {
    logic [N-1:0] pend;
    logic [N-1:0] out;
  } flg_irq_state_t;

  flg_irq_state_t st;
  flg_irq_state_t next_st;

  // ---------------------------------------------------------------
  // Hold and release
  // ---------------------------------------------------------------
  // New arrivals win over the release of the same source
  always_comb
  begin
    next_st = st;
    next_st.out = '0;
    if (!busy && irqEnable)
    begin
      for (int i = N - 1; i >= 0; i--)
        if (st.pend[i])
          next_st.out = N'(1) << i;
    end
    next_st.pend = (st.pend & ~next_st.out) | irqIn;
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign irqOut = st.out;
endmodule
`default_nettype wire

// File: verilog/flg_page_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "flg_guard_regs.svh"
module flg_page_decode
(
  // Address and lock setting
  input  wire logic [15:0] addr,
  input  wire logic        scratch,
  input  wire logic [7:0]  lockByte,
  // Classification
  output logic             anyLocked,
  output logic             pageLocked,
  output logic             isLockPage,
  output logic             isReserved
);
  // ---------------------------------------------------------------
  // Page classification
  // ---------------------------------------------------------------
  logic [7:0] lockCount;
  logic [5:0] page;

  // Count of locked pages is the inverse of the lock byte
  always_comb
  begin
    lockCount  = ~lockByte;
    page       = addr[15:`FLG_PAGE_LSB];
    anyLocked  = (lockCount != 8'h00);
    isLockPage = !scratch && (page == `FLG_LOCK_PAGE);
    isReserved = !scratch && (page > `FLG_LOCK_PAGE);
    if (scratch)
      pageLocked = (lockCount >= {2'b00, `FLG_LOCK_PAGE});
    else if (isLockPage)
      pageLocked = anyLocked;
    else
      pageLocked = ({2'b00, page} < lockCount);
  end
endmodule
`default_nettype wire
